// file: hw/hco_cursor_overlay.sv
// Hardware cursor overlay: registers, palette write sequence and pixel mixing.
`timescale 1ns/100ps
module hco_cursor_overlay (
   input wire logic clk,
   input wire logic reset_n,
   input wire hco_pkg::hco_host_t host,
   output logic [15:0] hostRdData,
   input wire logic indexedMode,
   input wire logic lineStart,
   input wire logic [10:0] lineRow,
   input wire hco_pkg::hco_pixel_t pixIn,
   output logic memReq,
   output logic [11:0] memAddr,
   input wire logic [15:0] memRdData,
   input wire logic memRdValid,
   output logic pixOutValid,
   output logic pixOutCursor,
   output logic [17:0] pixOut,
   output logic [17:0] lutColor
);
   hco_pkg::hco_cfg_t cfg_q;
   logic [7:0] palIndex_q;
   logic [11:0] palRg_q;
   logic palArmed_q;
   logic palRgDone_q;
   logic rowActive_q;
   logic [4:0] patRow_q;
   logic fetchStart_q;
   logic [31:0] plane0;
   logic [31:0] plane1;
   logic [11:0] colStart;
   logic [11:0] rowStart;
   logic [11:0] colOff;
   logic [11:0] rowOff;
   logic inCol;
   logic hit;
   logic [1:0] code;
   logic [7:0] idx0;
   logic [7:0] idx1;
   logic [17:0] mixed;
   logic wrCtl, wrX, wrY, wrC0a, wrC0b, wrC1a, wrC1b, wrHot;
   logic wrPalIdx, wrPalRg, wrPalB;
   logic palWrEn;
   logic [11:0] lineBase;
   logic [15:0] rdMux;

   // Register write decode; the palette ports only react to write strobes.
   assign wrCtl = host.wr && host.addr == hco_pkg::HCO_OFF_CONTROL;
   assign wrX = host.wr && host.addr == hco_pkg::HCO_OFF_POS_X;
   assign wrY = host.wr && host.addr == hco_pkg::HCO_OFF_POS_Y;
   assign wrC0a = host.wr && host.addr == hco_pkg::HCO_OFF_COL0_RG;
   assign wrC0b = host.wr && host.addr == hco_pkg::HCO_OFF_COL0_B;
   assign wrC1a = host.wr && host.addr == hco_pkg::HCO_OFF_COL1_RG;
   assign wrC1b = host.wr && host.addr == hco_pkg::HCO_OFF_COL1_B;
   assign wrHot = host.wr && host.addr == hco_pkg::HCO_OFF_HOTSPOT;
   assign wrPalIdx = host.wr && host.addr == hco_pkg::HCO_OFF_PAL_INDEX;
   assign wrPalRg = host.wr && host.addr == hco_pkg::HCO_OFF_PAL_RG;
   assign wrPalB = host.wr && host.addr == hco_pkg::HCO_OFF_PAL_B;

   // Cursor configuration registers; every field resets to zero.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cfg_q.enable <= 1'b0;
         cfg_q.patSel <= 1'b0;
         cfg_q.posX <= hco_pkg::HCO_POS_RESET;
         cfg_q.posY <= hco_pkg::HCO_POS_RESET;
         cfg_q.hotX <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.hotY <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.red0 <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.green0 <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.blue0 <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.red1 <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.green1 <= hco_pkg::HCO_FIELD_RESET;
         cfg_q.blue1 <= hco_pkg::HCO_FIELD_RESET;
      end
      else
      begin
         if (wrCtl)
         begin
            cfg_q.enable <= host.wrData[hco_pkg::HCO_CTRL_EN_BIT];
            cfg_q.patSel <= host.wrData[hco_pkg::HCO_CTRL_SEL_BIT];
         end
         if (wrX)
         begin
            cfg_q.posX <= host.wrData[10:0];
         end
         if (wrY)
         begin
            cfg_q.posY <= host.wrData[10:0];
         end
         if (wrHot)
         begin
            cfg_q.hotY <= host.wrData[13:8];
            cfg_q.hotX <= host.wrData[5:0];
         end
         if (wrC0a)
         begin
            cfg_q.red0 <= host.wrData[13:8];
            cfg_q.green0 <= host.wrData[5:0];
         end
         if (wrC0b)
         begin
            cfg_q.blue0 <= host.wrData[5:0];
         end
         if (wrC1a)
         begin
            cfg_q.red1 <= host.wrData[13:8];
            cfg_q.green1 <= host.wrData[5:0];
         end
         if (wrC1b)
         begin
            cfg_q.blue1 <= host.wrData[5:0];
         end
      end
   end

   // Read mux; write-only palette registers and unmapped addresses read zero.
   always_comb
   begin
      rdMux = hco_pkg::HCO_REG_ZERO;
      unique case (host.addr)
         hco_pkg::HCO_OFF_CONTROL: rdMux = {13'h0000, cfg_q.patSel, 1'b0, cfg_q.enable};
         hco_pkg::HCO_OFF_POS_X: rdMux = {5'h00, cfg_q.posX};
         hco_pkg::HCO_OFF_POS_Y: rdMux = {5'h00, cfg_q.posY};
         hco_pkg::HCO_OFF_COL0_RG: rdMux = {2'h0, cfg_q.red0, 2'h0, cfg_q.green0};
         hco_pkg::HCO_OFF_COL0_B: rdMux = {10'h000, cfg_q.blue0};
         hco_pkg::HCO_OFF_COL1_RG: rdMux = {2'h0, cfg_q.red1, 2'h0, cfg_q.green1};
         hco_pkg::HCO_OFF_COL1_B: rdMux = {10'h000, cfg_q.blue1};
         hco_pkg::HCO_OFF_HOTSPOT: rdMux = {2'h0, cfg_q.hotY, 2'h0, cfg_q.hotX};
         default: rdMux = hco_pkg::HCO_REG_ZERO;
      endcase
   end

   // Read data is returned one cycle after the read strobe and then held.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hostRdData <= hco_pkg::HCO_REG_ZERO;
      end
      else if (host.rd)
      begin
         hostRdData <= rdMux;
      end
   end

   // Palette write sequence: index arms it, red/green then blue commit the entry.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         palIndex_q <= 8'h00;
         palRg_q <= 12'h000;
         palArmed_q <= 1'b0;
         palRgDone_q <= 1'b0;
      end
      else if (wrPalIdx)
      begin
         palIndex_q <= host.wrData[7:0];
         palArmed_q <= 1'b1;
         palRgDone_q <= 1'b0;
      end
      else if (wrPalRg && palArmed_q)
      begin
         palRg_q <= {host.wrData[13:8], host.wrData[5:0]};
         palRgDone_q <= 1'b1;
      end
      else if (palWrEn)
      begin
         palArmed_q <= 1'b0;
         palRgDone_q <= 1'b0;
      end
   end

   // A blue write without a preceding red/green write is dropped.
   assign palWrEn = wrPalB && palArmed_q && palRgDone_q;

   // Cursor indexes: low green bits give the top three, blue bits 5..1 the rest.
   assign idx0 = {cfg_q.green0[hco_pkg::HCO_IDX_HI_MSB:0],
                  cfg_q.blue0[5:hco_pkg::HCO_IDX_LO_LSB]};
   assign idx1 = {cfg_q.green1[hco_pkg::HCO_IDX_HI_MSB:0],
                  cfg_q.blue1[5:hco_pkg::HCO_IDX_LO_LSB]};

   // Image origin is position minus hotspot; modulo arithmetic handles the edge.
   assign colStart = {1'b0, cfg_q.posX} - {6'h00, cfg_q.hotX};
   assign rowStart = {1'b0, cfg_q.posY} - {6'h00, cfg_q.hotY};
   assign colOff = {1'b0, pixIn.col} - colStart;
   assign rowOff = {1'b0, lineRow} - rowStart;
   assign inCol = colOff < hco_pkg::HCO_CUR_SIZE;
   assign lineBase = (cfg_q.patSel ? hco_pkg::HCO_PAT1_BASE : hco_pkg::HCO_PAT0_BASE)
                     + {rowOff[4:0], 3'h0};

   // Line start decides whether this line crosses the cursor and starts the fetch.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rowActive_q <= 1'b0;
         patRow_q <= 5'h00;
         fetchStart_q <= 1'b0;
      end
      else
      begin
         fetchStart_q <= 1'b0;
         if (lineStart)
         begin
            rowActive_q <= cfg_q.enable && rowOff < hco_pkg::HCO_CUR_SIZE;
            patRow_q <= rowOff[4:0];
            fetchStart_q <= cfg_q.enable && rowOff < hco_pkg::HCO_CUR_SIZE;
         end
      end
   end

   logic [11:0] fetchBase_q;

   // The line base is captured so a register write mid-fetch cannot tear it.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fetchBase_q <= 12'h000;
      end
      else if (lineStart)
      begin
         fetchBase_q <= lineBase;
      end
   end

   hco_pattern_fetch u_fetch (
      .clk(clk),
      .reset_n(reset_n),
      .start(fetchStart_q),
      .lineBase(fetchBase_q),
      .memReq(memReq),
      .memAddr(memAddr),
      .memRdData(memRdData),
      .memRdValid(memRdValid),
      .plane0(plane0),
      .plane1(plane1),
      .done()
   );

   // Disabling the cursor hides it at once, even mid-line.
   assign hit = cfg_q.enable && rowActive_q && inCol;
   assign code = {plane1[colOff[4:0]], plane0[colOff[4:0]]};

   // Pixel mixing; indexed modes carry an 8-bit index in the low bits.
   always_comb
   begin
      mixed = indexedMode ? {10'h000, pixIn.data[7:0]} : {2'h0, pixIn.data};
      if (hit)
      begin
         unique case (code)
            2'b00: mixed = indexedMode ? {10'h000, idx0}
                                       : {cfg_q.red0, cfg_q.green0, cfg_q.blue0};
            2'b01: mixed = indexedMode ? {10'h000, idx1}
                                       : {cfg_q.red1, cfg_q.green1, cfg_q.blue1};
            2'b10: mixed = mixed;
            2'b11: mixed = indexedMode ? {10'h000, ~pixIn.data[7:0]}
                                       : {2'h0, ~pixIn.data};
         endcase
      end
   end

   // One pipeline stage from pixel input to output.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pixOutValid <= 1'b0;
         pixOutCursor <= 1'b0;
         pixOut <= 18'h00000;
      end
      else
      begin
         pixOutValid <= pixIn.valid;
         pixOutCursor <= pixIn.valid && hit && code != 2'b10;
         pixOut <= mixed;
      end
   end

   hco_palette_ram #(
      .DEPTH(256),
      .WIDTH(18)
   ) u_palette (
      .clk(clk),
      .reset_n(reset_n),
      .wrEn(palWrEn),
      .wrIndex(palIndex_q),
      .wrData({palRg_q, host.wrData[5:0]}),
      .rdIndex(mixed[7:0]),
      .rdData(lutColor)
   );

   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_index_write;
      wrPalIdx;
   endsequence

   // Host writes leave one idle cycle between strobes, so blue follows two edges later.
   sequence s_rg_then_blue;
      (wrPalRg && palArmed_q) ##1 (!wrPalIdx && !wrPalRg) ##1 wrPalB;
   endsequence

   a_pal_restart: assert property (s_index_write |=> palArmed_q && !palRgDone_q)
      else $error("index write did not restart the palette sequence");
   a_pal_commit: assert property (s_rg_then_blue |-> palWrEn)
      else $error("red/green then blue write did not commit the entry");
   a_pal_no_early: assert property (palWrEn |-> palRgDone_q && wrPalB ##1 !palArmed_q)
      else $error("palette commit lacked a port write or left the sequence armed");
   a_color0_out: assert property (pixIn.valid && hit && code == 2'b00 && !indexedMode
      |=> pixOut == {cfg_q.red0, cfg_q.green0, cfg_q.blue0} && pixOutCursor)
      else $error("direct colour 0 not output");
   a_color1_index: assert property (pixIn.valid && hit && code == 2'b01 && indexedMode
      |=> pixOut[7:0] == {cfg_q.green1[2:0], cfg_q.blue1[5:1]})
      else $error("colour 1 index wrong");
   a_transparent_pass: assert property (pixIn.valid && hit && code == 2'b10 && !indexedMode
      |=> pixOut == {2'h0, $past(pixIn.data)} && !pixOutCursor)
      else $error("transparent pixel altered video");
   a_invert_video: assert property (pixIn.valid && hit && code == 2'b11 && !indexedMode
      |=> pixOut[15:0] == ~$past(pixIn.data))
      else $error("inverted video not the complement");
   a_outside_pass: assert property (pixIn.valid && !inCol
      |=> !pixOutCursor && pixOut[15:0] == ($past(indexedMode) ? {8'h00, $past(pixIn.data[7:0])}
                                                              : $past(pixIn.data)))
      else $error("pixel outside the cursor was changed");
   a_disabled_hidden: assert property (!cfg_q.enable && pixIn.valid |=> !pixOutCursor)
      else $error("cursor shown while disabled");
   a_pattern_area: assert property (fetchStart_q |->
      fetchBase_q[11:8] == (cfg_q.patSel ? 4'hF : 4'hE) && fetchBase_q[2:0] == 3'h0)
      else $error("pattern fetch outside selected area");
endmodule

// file: shared/hco_pkg.sv
// Constants, register map and carrier types for the hardware cursor overlay.
package hco_pkg;
   localparam logic [7:0] HCO_OFF_CONTROL = 8'h20;
   localparam logic [7:0] HCO_OFF_POS_X = 8'h22;
   localparam logic [7:0] HCO_OFF_POS_Y = 8'h24;
   localparam logic [7:0] HCO_OFF_COL0_RG = 8'h26;
   localparam logic [7:0] HCO_OFF_COL0_B = 8'h28;
   localparam logic [7:0] HCO_OFF_COL1_RG = 8'h2A;
   localparam logic [7:0] HCO_OFF_COL1_B = 8'h2C;
   localparam logic [7:0] HCO_OFF_HOTSPOT = 8'h2E;
   localparam logic [7:0] HCO_OFF_PAL_INDEX = 8'h40;
   localparam logic [7:0] HCO_OFF_PAL_RG = 8'h42;
   localparam logic [7:0] HCO_OFF_PAL_B = 8'h44;
   localparam int HCO_CTRL_EN_BIT = 0;
   localparam int HCO_CTRL_SEL_BIT = 2;
   localparam int HCO_HI_FIELD_LSB = 8;
   localparam int HCO_IDX_HI_MSB = 2;
   localparam int HCO_IDX_LO_LSB = 1;
   localparam logic [11:0] HCO_PAT0_BASE = 12'hE00;
   localparam logic [11:0] HCO_PAT1_BASE = 12'hF00;
   localparam logic [11:0] HCO_CUR_SIZE = 12'h020;
   localparam logic [11:0] HCO_LINE_BYTES = 12'h008;
   localparam logic [11:0] HCO_WORD_BYTES = 12'h002;
   localparam logic [1:0] HCO_LAST_WORD = 2'h3;
   localparam logic [5:0] HCO_FIELD_RESET = 6'h00;
   localparam logic [10:0] HCO_POS_RESET = 11'h000;
   localparam logic [15:0] HCO_REG_ZERO = 16'h0000;

   typedef struct packed {
      logic enable;
      logic patSel;
      logic [10:0] posX;
      logic [10:0] posY;
      logic [5:0] hotX;
      logic [5:0] hotY;
      logic [5:0] red0;
      logic [5:0] green0;
      logic [5:0] blue0;
      logic [5:0] red1;
      logic [5:0] green1;
      logic [5:0] blue1;
   } hco_cfg_t;

   typedef struct packed {
      logic valid;
      logic [10:0] col;
      logic [15:0] data;
   } hco_pixel_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wrData;
      logic wr;
      logic rd;
   } hco_host_t;
endpackage

// file: hw/hco_palette_ram.sv
// Palette RAM with one write port and one registered read port.
`timescale 1ns/100ps
module hco_palette_ram #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 18
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wrEn,
   input wire logic [$clog2(DEPTH)-1:0] wrIndex,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic [$clog2(DEPTH)-1:0] rdIndex,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Storage has no reset; entries hold whatever software loaded last.
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrIndex] <= wrData;
      end
   end

   // The read is registered so the looked-up colour leaves from a flip-flop.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdData <= '0;
      end
      else
      begin
         rdData <= mem[rdIndex];
      end
   end
endmodule

// file: hw/hco_pattern_fetch.sv
// Fetches one cursor line of pattern data, four halfwords from frame memory.
`timescale 1ns/100ps
module hco_pattern_fetch (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [11:0] lineBase,
   output logic memReq,
   output logic [11:0] memAddr,
   input wire logic [15:0] memRdData,
   input wire logic memRdValid,
   output logic [31:0] plane0,
   output logic [31:0] plane1,
   output logic done
);
   typedef enum logic {HcoIdle, HcoBusy} hco_fetch_state_t;
   hco_fetch_state_t state_q;
   logic [1:0] word_q;
   logic [63:0] pat_q;

   // Request stays up for the whole line; each valid answers the current address.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= HcoIdle;
         word_q <= 2'h0;
         memReq <= 1'b0;
         memAddr <= 12'h000;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         unique case (state_q)
            HcoIdle:
            begin
               if (start)
               begin
                  state_q <= HcoBusy;
                  word_q <= 2'h0;
                  memReq <= 1'b1;
                  memAddr <= lineBase;
               end
            end
            HcoBusy:
            begin
               if (memRdValid)
               begin
                  word_q <= word_q + 2'h1;
                  memAddr <= memAddr + hco_pkg::HCO_WORD_BYTES;
                  if (word_q == hco_pkg::HCO_LAST_WORD)
                  begin
                     state_q <= HcoIdle;
                     memReq <= 1'b0;
                     done <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Little-endian halfwords shift in; the first two form plane 0.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pat_q <= '0;
      end
      else if (state_q == HcoBusy && memRdValid)
      begin
         pat_q <= {memRdData, pat_q[63:16]};
      end
   end

   assign plane0 = pat_q[31:0];
   assign plane1 = pat_q[63:32];

   a_fetch_step: assert property (@(posedge clk) disable iff (!reset_n)
      state_q == HcoBusy && memRdValid && word_q != hco_pkg::HCO_LAST_WORD
      |=> memReq && memAddr == $past(memAddr) + hco_pkg::HCO_WORD_BYTES)
      else $error("pattern fetch address did not step by one halfword");
endmodule

// file: dv/hco_frame_mem.sv
// Frame memory model answering cursor pattern fetches after a set delay.
`timescale 1ns/100ps
module hco_frame_mem (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] latency,
   input wire logic memReq,
   input wire logic [11:0] memAddr,
   output logic [15:0] memRdData,
   output logic memRdValid
);
   // Top 512 bytes held as halfwords, indexed by the halfword within E00..FFF.
   logic [15:0] mem [0:255];
   logic [3:0] waitQ;

   // Data turns to its inverse after the pulse so stale reads never look right.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         memRdValid <= 1'b0;
         memRdData <= 16'h5A5A;
         waitQ <= 4'h0;
      end
      else if (memRdValid)
      begin
         memRdValid <= 1'b0;
         memRdData <= ~memRdData;
         waitQ <= 4'h0;
      end
      else if (memReq && waitQ >= latency)
      begin
         memRdValid <= 1'b1;
         memRdData <= mem[memAddr[8:1]];
      end
      else if (memReq)
         waitQ <= waitQ + 4'h1;
   end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the cursor overlay with a frame memory model.
`timescale 1ns/100ps
module testbench;
   typedef struct packed {logic [7:0] a; logic [15:0] w; logic [15:0] r;} hco_row_t;
   localparam hco_row_t ROWS [0:9] = '{'{8'h20, 16'hFFFF, 16'h0005},
      '{8'h22, 16'hFFFF, 16'h07FF}, '{8'h24, 16'hFFFF, 16'h07FF}, '{8'h26, 16'hFFFF, 16'h3F3F},
      '{8'h28, 16'hFFFF, 16'h003F}, '{8'h2A, 16'hFFFF, 16'h3F3F}, '{8'h2C, 16'hFFFF, 16'h003F},
      '{8'h2E, 16'hFFFF, 16'h3F3F}, '{8'h40, 16'h00FF, 16'h0000}, '{8'h30, 16'hFFFF, 16'h0000}};
   logic clk, reset_n, indexedMode, lineStart, memReq, memRdValid, pixOutValid, pixOutCursor;
   hco_pkg::hco_host_t host;
   hco_pkg::hco_pixel_t pixIn;
   logic [15:0] hostRdData, memRdData, c0a, c0b, c1a, c1b;
   logic [10:0] lineRow, posX, posY, curRow;
   logic [11:0] memAddr;
   logic [17:0] pixOut, lutColor;
   logic [17:0] pal [0:255];
   bit known [0:255];
   logic [3:0] latency;
   logic [5:0] hx, hy;
   logic [31:0] p0, p1;
   logic en;
   int fail_count, check_count, cycles;

   hco_cursor_overlay hco_cursor_overlay_i (.clk(clk), .reset_n(reset_n), .host(host),
      .hostRdData(hostRdData), .indexedMode(indexedMode), .lineStart(lineStart),
      .lineRow(lineRow), .pixIn(pixIn), .memReq(memReq), .memAddr(memAddr),
      .memRdData(memRdData), .memRdValid(memRdValid), .pixOutValid(pixOutValid),
      .pixOutCursor(pixOutCursor), .pixOut(pixOut), .lutColor(lutColor));
   hco_frame_mem hco_frame_mem_i (.clk(clk), .reset_n(reset_n), .latency(latency),
      .memReq(memReq), .memAddr(memAddr), .memRdData(memRdData), .memRdValid(memRdValid));

   always #2.5 clk = ~clk;

   // Cuts a hang short; the ceiling is far above the few hundred cycles needed.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_pix(input logic [18:0] got, input logic [18:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Strobes drop for a full cycle between accesses so no signal is set twice at once.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host.addr = a;
      host.wrData = d;
      host.wr = 1'b1;
      @(posedge clk);
      #1;
      host.wr = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      host.addr = a;
      host.rd = 1'b1;
      @(posedge clk);
      #1;
      host.rd = 1'b0;
      @(posedge clk);
      #1;
      d = hostRdData;
   endtask

   task automatic setup(input logic [15:0] ctl, input logic [10:0] x, input logic [10:0] y,
      input logic [5:0] hxv, input logic [5:0] hyv, input logic [15:0] a0,
      input logic [15:0] b0, input logic [15:0] a1, input logic [15:0] b1);
      en = ctl[0];
      posX = x;
      posY = y;
      hx = hxv;
      hy = hyv;
      c0a = a0;
      c0b = b0;
      c1a = a1;
      c1b = b1;
      wr(8'h20, ctl);
      wr(8'h22, {5'h00, x});
      wr(8'h24, {5'h00, y});
      wr(8'h2E, {2'h0, hyv, 2'h0, hxv});
      wr(8'h26, a0);
      wr(8'h28, b0);
      wr(8'h2A, a1);
      wr(8'h2C, b1);
   endtask

   task automatic pat(input logic [7:0] hw, input logic [31:0] a, input logic [31:0] b);
      p0 = a;
      p1 = b;
      hco_frame_mem_i.mem[hw] = a[15:0];
      hco_frame_mem_i.mem[hw + 8'h01] = a[31:16];
      hco_frame_mem_i.mem[hw + 8'h02] = b[15:0];
      hco_frame_mem_i.mem[hw + 8'h03] = b[31:16];
   endtask

   // Expected {cursor flag, pixel} worked out from the pattern and the registers.
   function automatic logic [18:0] exp_pix(input logic [10:0] c, input logic [15:0] d);
      logic [11:0] dx;
      logic [11:0] dy;
      logic [1:0] code;
      logic [17:0] k0;
      logic [17:0] k1;
      dx = {1'b0, c} - {1'b0, posX} + {6'h00, hx};
      dy = {1'b0, curRow} - {1'b0, posY} + {6'h00, hy};
      code = (en && dx < 12'h020 && dy < 12'h020) ? {p1[dx[4:0]], p0[dx[4:0]]} : 2'b10;
      k0 = indexedMode ? {10'h000, c0a[2:0], c0b[5:1]} : {c0a[13:8], c0a[5:0], c0b[5:0]};
      k1 = indexedMode ? {10'h000, c1a[2:0], c1b[5:1]} : {c1a[13:8], c1a[5:0], c1b[5:0]};
      case (code)
         2'b00: return {1'b1, k0};
         2'b01: return {1'b1, k1};
         2'b10: return indexedMode ? {11'h000, d[7:0]} : {3'h0, d};
         default: return indexedMode ? {11'h400, ~d[7:0]} : {3'h4, ~d};
      endcase
   endfunction

   // One display line: fetch check, then a back-to-back pixel run across the cursor.
   task automatic run_line(input logic [10:0] row, input logic fetch, input logic [11:0] addr);
      int n;
      logic [18:0] e;
      curRow = row;
      lineRow = row;
      lineStart = 1'b1;
      @(posedge clk);
      #1;
      lineStart = 1'b0;
      n = 0;
      while (memReq !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_reg({15'h0000, memReq}, {15'h0000, fetch});
      if (fetch)
         chk_reg({4'h0, memAddr}, {4'h0, addr});
      repeat (30) @(posedge clk);
      #1;
      for (int c = 90; c < 136; c++)
      begin
         pixIn = {1'b1, c[10:0], 16'hEA9C ^ c[15:0]};
         @(posedge clk);
         #1;
         e = exp_pix(c[10:0], pixIn.data);
         chk_pix({pixOutCursor, pixOut}, e);
         chk_reg({15'h0000, pixOutValid}, 16'h0001);
         // The palette is read from the same edge that registers the pixel.
         if (indexedMode && known[e[7:0]])
            chk_pix({1'b0, lutColor}, {1'b0, pal[e[7:0]]});
      end
      pixIn.valid = 1'b0;
      @(posedge clk);
      #1;
      chk_reg({15'h0000, pixOutValid}, 16'h0000);
   endtask

   initial
   begin
      logic [15:0] d;
      clk = 1'b0;
      reset_n = 1'b0;
      host = '0;
      indexedMode = 1'b0;
      lineStart = 1'b0;
      lineRow = 11'h000;
      pixIn = '0;
      latency = 4'h0;
      repeat (4) @(posedge clk);
      #1;
      reset_n = 1'b1;
      // Reset value, then write and read back each register and two unreadable places.
      foreach (ROWS[i])
      begin
         rd(ROWS[i].a, d);
         chk_reg(d, 16'h0000);
         wr(ROWS[i].a, ROWS[i].w);
         rd(ROWS[i].a, d);
         chk_reg(d, ROWS[i].r);
      end
      // Direct colours, pattern 0, line 1 of the cursor, prompt memory.
      setup(16'h0001, 11'h064, 11'h014, 6'h03, 6'h02, 16'h2A15, 16'h0033, 16'h0C3F, 16'h0011);
      pat(8'h04, 32'h3333_3333, 32'h0F0F_0F0F);
      run_line(11'h013, 1'b1, 12'hE08);
      run_line(11'h032, 1'b0, 12'h000);
      // Palette: restart, lone blue writes and writes after commit must all be ignored.
      wr(8'h40, 16'h00FF);
      wr(8'h42, 16'h2A15);
      wr(8'h44, 16'h0033);
      wr(8'h40, 16'h0092);
      wr(8'h42, 16'h1111);
      wr(8'h40, 16'h00FF);
      wr(8'h44, 16'h0001);
      wr(8'h40, 16'h0092);
      wr(8'h42, 16'h3F00);
      wr(8'h44, 16'h0015);
      wr(8'h44, 16'h002A);
      pal[8'hFF] = {6'h2A, 6'h15, 6'h33};
      pal[8'h92] = {6'h3F, 6'h00, 6'h15};
      known[8'hFF] = 1'b1;
      known[8'h92] = 1'b1;
      // Indexed colours with don't-care bits set, pattern 1, slow memory.
      indexedMode = 1'b1;
      latency = 4'h3;
      setup(16'h0005, 11'h064, 11'h012, 6'h00, 6'h00, 16'h3F3C, 16'h0025, 16'h3FFF, 16'h003F);
      pat(8'h80, 32'h5A5A_C3C3, 32'h00FF_0F0F);
      run_line(11'h012, 1'b1, 12'hF00);
      wr(8'h20, 16'h0000);
      en = 1'b0;
      run_line(11'h012, 1'b0, 12'h000);
      // A second reset in mid-run clears the registers again.
      reset_n = 1'b0;
      @(posedge clk);
      #1;
      reset_n = 1'b1;
      rd(8'h2E, d);
      chk_reg(d, 16'h0000);
      // X position still holds a non-zero value here, so this read proves the reset.
      rd(8'h22, d);
      chk_reg(d, 16'h0000);
      wrap_up();
   end
endmodule
